// ===== apnsr_regs.v
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "apnsr_map.vh"

module apnsr_regs #(
   parameter AW = 12
) (
   // clock and reset
   input wire i_clk,
   input wire i_sys_rst,
   // ahb-lite slave
   input wire i_hsel,
   input wire [AW-1:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output wire o_hreadyout,
   output wire o_hresp,
   output reg [31:0] o_hrdata,
   // from the autonegotiation engine
   input wire i_page_valid,
   input wire [15:0] i_page_word,
   input wire i_pd_fault,
   input wire i_an_detect,
   input wire i_an_restart,
   // register contents for the rest of the phy
   output reg [15:0] o_partner_ability,
   output reg [15:0] o_autoneg_expansion,
   output reg o_partner_pause_support
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function [9:0] word_index;
   input [AW-1:0] addr;
   reg [AW-1:0] sh;
   begin
      sh = addr >> 2;
      word_index = sh[9:0];
   end
endfunction

// one decode serves the read mux for every word
function [31:0] read_word;
   input [9:0] idx;
   input [15:0] pa;
   input [15:0] ae;
   input [15:0] cw;
   begin
      if (idx == `APNSR_IDX_PARTNER) begin
         read_word = {16'h0000, pa};
      end else if (idx == `APNSR_IDX_EXPANSION) begin
         read_word = {16'h0000, ae};
      end else if (idx == `APNSR_IDX_CONTROL) begin
         read_word = {16'h0000, cw};
      end else begin
         // unmapped words read zero so probing software sees no garbage
         read_word = 32'h00000000;
      end
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// state

reg partner_next_page;
reg partner_ack;
reg partner_remote_fault;
reg partner_pause_support;
reg [4:0] partner_tech;
reg [4:0] partner_selector;
reg parallel_detect_fault;
reg partner_next_page_capable;
reg page_received;
reg partner_autoneg_capable;
reg freeze;
reg dp_write;
reg [9:0] dp_index;

wire [15:0] partner_ability;
wire [15:0] autoneg_expansion;
wire [15:0] control_word;
wire addr_take;
wire rd_take;
wire exp_read;
wire wr_partner;
wire wr_control;
wire restart;
wire capture;
wire [9:0] addr_index;

// zero wait state, every access answers okay
assign o_hreadyout = 1'b1;
assign o_hresp = `APNSR_HRESP_OKAY;

assign addr_index = word_index(i_haddr);
assign addr_take = i_hsel & i_htrans[1] & i_hready;
assign rd_take = addr_take & ~i_hwrite;
assign exp_read = rd_take & (addr_index == `APNSR_IDX_EXPANSION);
assign wr_partner = dp_write & (dp_index == `APNSR_IDX_PARTNER);
assign wr_control = dp_write & (dp_index == `APNSR_IDX_CONTROL);
assign restart = i_an_restart | (wr_control & i_hwdata[`APNSR_CT_RESTART]);
// frozen captures keep the last page stable for software inspection
assign capture = i_page_valid & ~freeze;

////////////////////////////////////////////////////////////////////////////////
// read words

// reserved bits always read zero
assign partner_ability = {partner_next_page, partner_ack, partner_remote_fault,
   2'b00, partner_pause_support, partner_tech, partner_selector};

assign autoneg_expansion = {11'h000, parallel_detect_fault,
   partner_next_page_capable, `APNSR_LOCAL_NP_VAL, page_received,
   partner_autoneg_capable};

// restart is a strobe and never reads back
assign control_word = {14'h0000, freeze, 1'b0};

////////////////////////////////////////////////////////////////////////////////
// bus pipeline

// read data is taken at the address phase, before any read clear lands
always @(posedge i_clk) begin
   if (i_sys_rst) begin
      dp_write <= 1'b0;
      dp_index <= 10'h000;
      o_hrdata <= 32'h00000000;
   end else begin
      dp_write <= addr_take & i_hwrite;
      if (addr_take) begin
         dp_index <= addr_index;
      end
      if (rd_take) begin
         o_hrdata <= read_word(addr_index, partner_ability, autoneg_expansion, control_word);
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// partner ability

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      partner_next_page <= 1'b0;
   end else if (capture) begin
      partner_next_page <= i_page_word[`APNSR_PA_NEXT_PAGE];
   end else if (restart) begin
      partner_next_page <= 1'b0;
   end
end

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      partner_ack <= 1'b0;
   end else if (capture) begin
      partner_ack <= i_page_word[`APNSR_PA_ACK];
   end else if (restart) begin
      partner_ack <= 1'b0;
   end
end

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      partner_remote_fault <= 1'b0;
   end else if (capture) begin
      partner_remote_fault <= i_page_word[`APNSR_PA_RFAULT];
   end else if (restart) begin
      partner_remote_fault <= 1'b0;
   end
end

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      partner_pause_support <= 1'b0;
   end else if (capture) begin
      partner_pause_support <= i_page_word[`APNSR_PA_PAUSE];
   end else if (restart) begin
      partner_pause_support <= 1'b0;
   end else if (wr_partner) begin
      partner_pause_support <= i_hwdata[`APNSR_PA_PAUSE];
   end
end

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      partner_tech <= `APNSR_RST_TECH;
   end else if (capture) begin
      partner_tech <= i_page_word[`APNSR_PA_TECH_HI:`APNSR_PA_TECH_LO];
   end else if (restart) begin
      partner_tech <= `APNSR_RST_TECH;
   end
end

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      partner_selector <= `APNSR_RST_SEL;
   end else if (capture) begin
      partner_selector <= i_page_word[`APNSR_PA_SEL_HI:`APNSR_PA_SEL_LO];
   end else if (restart) begin
      partner_selector <= `APNSR_RST_SEL;
   end
end

////////////////////////////////////////////////////////////////////////////////
// expansion
// a new event outranks a read clear in the same cycle, so none is lost

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      parallel_detect_fault <= 1'b0;
   end else if (i_pd_fault) begin
      parallel_detect_fault <= 1'b1;
   end else if (exp_read) begin
      parallel_detect_fault <= 1'b0;
   end
end

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      page_received <= 1'b0;
   end else if (capture) begin
      page_received <= 1'b1;
   end else if (exp_read) begin
      page_received <= 1'b0;
   end
end

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      partner_next_page_capable <= 1'b0;
   end else if (capture) begin
      partner_next_page_capable <= i_page_word[`APNSR_PA_NEXT_PAGE];
   end else if (restart) begin
      partner_next_page_capable <= 1'b0;
   end
end

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      partner_autoneg_capable <= 1'b0;
   end else if (i_an_detect) begin
      partner_autoneg_capable <= 1'b1;
   end else if (restart) begin
      partner_autoneg_capable <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// control

// freeze holds until software drops it
always @(posedge i_clk) begin
   if (i_sys_rst) begin
      freeze <= 1'b0;
   end else if (wr_control) begin
      freeze <= i_hwdata[`APNSR_CT_FREEZE];
   end
end

////////////////////////////////////////////////////////////////////////////////
// register copies

// copies lag the fields by one cycle; a flop here eases timing into the phy
always @(posedge i_clk) begin
   if (i_sys_rst) begin
      o_partner_ability <= 16'h0000;
   end else begin
      o_partner_ability <= partner_ability;
   end
end

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      o_autoneg_expansion <= 16'h0000;
   end else begin
      o_autoneg_expansion <= autoneg_expansion;
   end
end

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      o_partner_pause_support <= 1'b0;
   end else begin
      o_partner_pause_support <= partner_pause_support;
   end
end

endmodule
`default_nettype wire

// ===== apnsr_map.vh
`ifndef APNSR_MAP_VH
`define APNSR_MAP_VH

// register indexes, byte address is four times the index
`define APNSR_IDX_PARTNER 10'h005
`define APNSR_IDX_EXPANSION 10'h006
`define APNSR_IDX_CONTROL 10'h007

// partner ability fields
`define APNSR_PA_NEXT_PAGE 15
`define APNSR_PA_ACK 14
`define APNSR_PA_RFAULT 13
`define APNSR_PA_PAUSE 10
`define APNSR_PA_TECH_HI 9
`define APNSR_PA_TECH_LO 5
`define APNSR_PA_SEL_HI 4
`define APNSR_PA_SEL_LO 0

// expansion fields
`define APNSR_EX_PD_FAULT 4
`define APNSR_EX_LP_NP 3
`define APNSR_EX_LOCAL_NP 2
`define APNSR_EX_PAGE_RX 1
`define APNSR_EX_LP_AN 0

// control fields
`define APNSR_CT_RESTART 0
`define APNSR_CT_FREEZE 1

// reset values
`define APNSR_RST_TECH 5'h00
`define APNSR_RST_SEL 5'h00
`define APNSR_LOCAL_NP_VAL 1'b0

// ahb encodings
`define APNSR_HRESP_OKAY 1'b0

`endif

// ===== apnsr_regs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module apnsr_chk #(
   parameter AW = 12
) (
   // bus
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_hsel,
   input wire logic [AW-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   // engine and register copies
   input wire logic i_page_valid,
   input wire logic i_pd_fault,
   input wire logic i_an_detect,
   input wire logic i_an_restart,
   input wire logic [15:0] o_partner_ability,
   input wire logic [15:0] o_autoneg_expansion
);
   logic rd_exp;
   logic rd_q;
   assign rd_exp = i_hsel && i_htrans[1] && i_hready && !i_hwrite && (i_haddr >> 2) == 6;
   // copies lag the fields by one cycle, so a read is seen one cycle late
   always @(posedge i_clk) rd_q <= i_sys_rst ? 1'b0 : rd_exp;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   local_np_a: assert property (!o_autoneg_expansion[2])
      else $error("local np set");
   resv_zero_a: assert property (o_partner_ability[12:11] == 2'h0)
      else $error("reserved set");
   np_mirror_a: assert property (o_autoneg_expansion[3] == o_partner_ability[15])
      else $error("np capable off");
   fault_set_a: assert property (i_pd_fault |=> ##1 o_autoneg_expansion[4])
      else $error("fault not latched");
   fault_hold_a: assert property (o_autoneg_expansion[4] && !rd_q |=> o_autoneg_expansion[4])
      else $error("fault lost");
   fault_clr_a: assert property (rd_exp && !i_pd_fault |=> ##1 !o_autoneg_expansion[4])
      else $error("fault not cleared");
   page_hold_a: assert property (o_autoneg_expansion[1] && !rd_q |=> o_autoneg_expansion[1])
      else $error("page flag lost");
   page_clr_a: assert property (rd_exp && !i_page_valid |=> ##1 !o_autoneg_expansion[1])
      else $error("page flag kept");
   an_set_a: assert property (i_an_detect && !i_an_restart |=> ##1 o_autoneg_expansion[0])
      else $error("an capable unset");
endmodule
bind apnsr_regs apnsr_chk #(.AW(AW)) apnsr_chk_inst (.*);
`default_nettype wire

// ===== apnsr_link_partner.sv
`timescale 1ns/10ps
`default_nettype none
module apnsr_link_partner (
   input wire logic i_clk,
   output var logic i_page_valid,
   output var logic [15:0] i_page_word,
   output var logic i_pd_fault,
   output var logic i_an_detect
);
   initial {i_page_valid, i_page_word, i_pd_fault, i_an_detect} = '0;
   task automatic send(input logic [15:0] w);
      @(posedge i_clk);
      i_page_valid <= 1'b1;
      i_an_detect <= 1'b1;
      i_page_word <= w;
      @(posedge i_clk);
      i_page_valid <= 1'b0;
      i_an_detect <= 1'b0;
      // stale word must not look valid
      i_page_word <= ~w;
   endtask
   task automatic fault;
      @(posedge i_clk);
      i_pd_fault <= 1'b1;
      @(posedge i_clk);
      i_pd_fault <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== test_autoneg_partner_status_regs.sv
`timescale 1ns/10ps
`default_nettype none
module test_autoneg_partner_status_regs;
   logic i_clk, i_sys_rst, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp, rd_ph;
   logic [11:0] i_haddr;
   logic [1:0] i_htrans;
   logic [2:0] i_hsize;
   logic [31:0] i_hwdata, o_hrdata;
   logic [31:0] exp_q[$];
   logic [31:0] exp_v;
   logic [11:0] adr_v;
   logic [11:0] adr_q[$];
   logic i_page_valid, i_pd_fault, i_an_detect, i_an_restart, o_partner_pause_support;
   logic [15:0] i_page_word, o_partner_ability, o_autoneg_expansion, w;
   int errors, n_tests;
   apnsr_regs apnsr_regs_inst (.*);
   apnsr_link_partner apnsr_link_partner_inst (.*);
   assign i_hready = o_hreadyout;
   ////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
      n_tests++;
      if (seen !== e) begin
         errors++;
         $display("FAIL %s exp %h seen %h", nm, e, seen);
      end
   endtask
   task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
      i_htrans <= 2'h2;
      i_haddr <= a;
      i_hwrite <= wr;
      do @(posedge i_clk); while (i_hready !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      rd_ph <= !wr;
      do @(posedge i_clk); while (i_hready !== 1'b1);
      rd_ph <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      adr_q.push_back(a);
      xfer(a, 1'b0, 32'h0);
   endtask
   task final_report;
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge i_clk) begin
      if (rd_ph && i_hready) begin
         exp_v = exp_q.pop_front();
         adr_v = adr_q.pop_front();
         check("hrdata", o_hrdata, exp_v);
         check("hresp", {31'h0, o_hresp}, 32'h0);
         // copies lag the fields, so they match the word read at this edge
         if (adr_v == 12'h014) begin
            check("ability copy", {16'h0, o_partner_ability}, exp_v);
            check("pause copy", {31'h0, o_partner_pause_support}, {31'h0, exp_v[10]});
         end else if (adr_v == 12'h018) begin
            check("expansion copy", {16'h0, o_autoneg_expansion}, exp_v);
         end
      end
   end
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      #200000;
      errors++;
      final_report;
   end
   initial begin
      {i_hwrite, i_an_restart, rd_ph, i_htrans, i_haddr, i_hwdata} = '0;
      i_sys_rst = 1'b1;
      i_hsel = 1'b1;
      i_hsize = 3'h2;
      void'($urandom(32'h170F));
      repeat (12) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      rd(12'h014, 32'h0);
      rd(12'h018, 32'h0);
      for (int k = 0; k < 4; k++) begin
         w = 16'($urandom());
         apnsr_link_partner_inst.send(w);
         rd(12'h014, {16'h0, w & 16'hE7FF});
         rd(12'h018, {28'h0, w[15], 3'h3});
         rd(12'h018, {28'h0, w[15], 3'h1});
      end
      apnsr_link_partner_inst.fault();
      // idle gap: flag must outlive the fault pulse
      repeat (5) @(posedge i_clk);
      rd(12'h018, {27'h0, 1'b1, w[15], 3'h1});
      rd(12'h018, {28'h0, w[15], 3'h1});
      // only the pause bit is writable; ack and the other captured fields keep their values
      xfer(12'h014, 1'b1, 32'hA7FF);
      rd(12'h014, {16'h0, (w & 16'hE3FF) | 16'h0400});
      rd(12'h03C, 32'h0);
      apnsr_link_partner_inst.send(16'h2000);
      rd(12'h014, 32'h2000);
      rd(12'h018, 32'h3);
      // frozen capture drops pages and leaves the latch alone
      xfer(12'h01C, 1'b1, 32'h2);
      apnsr_link_partner_inst.send(16'hFFFF);
      rd(12'h018, 32'h1);
      rd(12'h014, 32'h2000);
      // software restart clears captured data and drops the freeze
      xfer(12'h01C, 1'b1, 32'h1);
      rd(12'h014, 32'h0);
      rd(12'h018, 32'h0);
      apnsr_link_partner_inst.send(w);
      rd(12'h018, {28'h0, w[15], 3'h3});
      i_an_restart <= 1'b1;
      @(posedge i_clk);
      i_an_restart <= 1'b0;
      rd(12'h014, 32'h0);
      rd(12'h018, 32'h0);
      @(posedge i_clk);
      final_report;
   end
endmodule
`default_nettype wire
